/* File: prs_core_model.sv */
// core-side model: command issue and program memory contents
`timescale 1ns/1ps
module prs_core_model (
    input wire logic pclk,
    input wire logic [prs_pkg::PC_W-1:0] pc,
    output prs_pkg::prs_cmd_s cmd,
    output logic [prs_pkg::WORD_W-1:0] flash_rdata
);
    initial cmd = '0;
    // pattern of the low 16 address bits, so words differ only within each 64K block
    assign flash_rdata = pc[15:0] ^ 16'ha55a;
    // one sequencer issues everything, so no interrupt op can land
    // while software holds the top entry registers
    task automatic issue(input prs_pkg::prs_op_e op, input logic fast,
                         input logic [prs_pkg::PC_W-1:0] tgt,
                         input prs_pkg::prs_shadow_s sv, input logic [7:0] lo);
        @(posedge pclk);
        cmd <= '{valid: 1'b1, op: op, fast: fast, target: tgt, low_data: lo, save: sv};
        @(posedge pclk);
        cmd <= '0;
    endtask : issue
    task automatic call_return(input logic [prs_pkg::PC_W-1:0] tgt);
        @(posedge pclk);
        cmd <= '{valid: 1'b1, op: prs_pkg::OP_CALL, fast: 1'b0, target: tgt,
                 low_data: 8'h00, save: '0};
        @(posedge pclk);
        cmd.op <= prs_pkg::OP_RETURN;
        @(posedge pclk);
        cmd <= '0;
    endtask : call_return
endmodule : prs_core_model

/* File: prs_counter_stack.sv */
// program counter, latches, return stack and fast shadow with an apb register port
// Function
// [RQ1] fetches above implemented memory, within the 21-bit space, return zero
// [RQ2] reset starts at 0000h; high interrupt vectors 0008h, low 0018h
// [RQ3] counter is three bytes; only low byte directly accessible, upper via latches; here the read-only counter view also reads all 21 bits
// [RQ4] writing low byte loads high and upper latches into the counter
// [RQ5] reading low byte copies counter upper bytes into the latches
// [RQ6] counter bit 0 is always zero; sequential step adds two
// [RQ7] jumps, branches, relative calls load counter directly, latches unused
// [RQ8] calls and interrupts push, returns pop; latches stay untouched
// [RQ9] return stack is 31 entries of 21 bits behind a 5-bit pointer
// [RQ10] push increments pointer then writes; pop reads entry then decrements
// [RQ11] every reset clears the pointer; pointer zero has no entry
// [RQ12] top entry readable and writable as upper, high and low bytes
// [RQ13] software masks interrupts while touching the top entry registers
// [RQ14] full flag sets after 31 pushes; cleared by software or power-on
// [RQ15] overflow reset on: 31st push stores pc plus two, flags, resets
// [RQ16] overflow reset off: pointer goes to 31 and holds, entry kept
// [RQ17] pop at zero loads zero, sets underflow, pointer stays zero
// [RQ18] overflow reset on makes full or underflow also reset the device
// [RQ19] pointer register: full bit7, underflow bit6, bit5 zero, pointer 4-0
// [RQ20] software push stores counter; software pop only decrements pointer
// [RQ21] interrupts load the one-level shadow; fast interrupt return restores
// [RQ22] fast call saves shadow; fast return restores it
// [RQ23] pointer write updates top view at once; writing ones to flags ignored
//
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module prs_counter_stack #(
    parameter logic [prs_pkg::PC_W-1:0] MEM_BYTES = 21'h004000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [prs_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire prs_pkg::prs_cmd_s cmd,
    input wire logic [prs_pkg::WORD_W-1:0] flash_rdata,
    output logic [prs_pkg::PC_W-1:0] pc,
    output logic [prs_pkg::WORD_W-1:0] fetch_word,
    output logic [7:0] read_low_data,
    output logic restore_valid,
    output prs_pkg::prs_shadow_s restore,
    output logic device_reset,
    output logic [7:0] return_stack_pointer
);

    typedef struct packed {
        logic [prs_pkg::PC_W-1:0] pc;
        logic [7:0] counter_high_latch;
        logic [4:0] counter_upper_latch;
        logic [prs_pkg::PTR_W-1:0] ptr;
        logic stack_full_flag;
        logic stack_underflow_flag;
        logic overflow_reset_enable;
        logic [prs_pkg::STK_DEPTH-1:0][prs_pkg::PC_W-1:0] stk;
        prs_pkg::prs_shadow_s shadow;
        prs_pkg::prs_shadow_s restore;
        logic restore_valid;
        logic device_reset;
        logic [prs_pkg::WORD_W-1:0] fetch_word;
        logic [7:0] read_low_data;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } prs_state_s;

    prs_state_s s;
    prs_state_s next_s;
    logic push;
    logic pop;
    logic pop_load;
    logic [prs_pkg::PC_W-1:0] push_val;
    logic [prs_pkg::PC_W-1:0] top_entry;
    logic apb_go;
    logic apb_wr_low;
    logic apb_wr_ptr;

    // entry behind pointer zero does not exist, so the view reads zero there
    assign top_entry = (s.ptr == prs_pkg::PTR_EMPTY) ? '0 : s.stk[s.ptr - 5'h01]; // [RQ11] [RQ12]
    assign apb_go = psel && penable && !s.pready;
    assign apb_wr_low = apb_go && pwrite && (paddr == prs_pkg::OFS_COUNTER_LOW);
    assign apb_wr_ptr = apb_go && pwrite && (paddr == prs_pkg::OFS_STACK_POINTER);

    always_comb begin
        next_s = s;
        next_s.pready = 1'b0;
        next_s.pslverr = 1'b0;
        next_s.restore_valid = 1'b0;
        next_s.device_reset = 1'b0;
        push = 1'b0;
        pop = 1'b0;
        pop_load = 1'b0;
        push_val = s.pc;
        // out-of-range fetch returns an all-zero word, a no-operation
        next_s.fetch_word = (s.pc < MEM_BYTES) ? flash_rdata : '0; // [RQ1]

        // bus side: one wait state so that all bus outputs come from flops
        if (apb_go) begin
            next_s.pready = 1'b1;
            next_s.prdata = '0;
            case (paddr)
                prs_pkg::OFS_COUNTER_LOW: begin
                    if (pwrite) begin
                        next_s.pc = {s.counter_upper_latch, s.counter_high_latch,
                                     pwdata[7:0]}; // [RQ3] [RQ4]
                    end else begin
                        next_s.prdata = {24'h000000, s.pc[7:0]};
                        next_s.counter_high_latch = s.pc[15:8]; // [RQ5]
                        next_s.counter_upper_latch = s.pc[20:16]; // [RQ5]
                    end
                end
                prs_pkg::OFS_HIGH_LATCH: begin
                    if (pwrite) begin
                        next_s.counter_high_latch = pwdata[7:0];
                    end
                    next_s.prdata = {24'h000000, s.counter_high_latch};
                end
                prs_pkg::OFS_UPPER_LATCH: begin
                    if (pwrite) begin
                        next_s.counter_upper_latch = pwdata[4:0];
                    end
                    next_s.prdata = {27'h0000000, s.counter_upper_latch};
                end
                prs_pkg::OFS_TOP_LOW: begin
                    if (pwrite && s.ptr != prs_pkg::PTR_EMPTY) begin
                        next_s.stk[s.ptr - 5'h01][7:0] = pwdata[7:0]; // [RQ12]
                    end
                    next_s.prdata = {24'h000000, top_entry[7:0]};
                end
                prs_pkg::OFS_TOP_HIGH: begin
                    if (pwrite && s.ptr != prs_pkg::PTR_EMPTY) begin
                        next_s.stk[s.ptr - 5'h01][15:8] = pwdata[7:0]; // [RQ12]
                    end
                    next_s.prdata = {24'h000000, top_entry[15:8]};
                end
                prs_pkg::OFS_TOP_UPPER: begin
                    if (pwrite && s.ptr != prs_pkg::PTR_EMPTY) begin
                        next_s.stk[s.ptr - 5'h01][20:16] = pwdata[4:0]; // [RQ12]
                    end
                    next_s.prdata = {27'h0000000, top_entry[20:16]};
                end
                prs_pkg::OFS_STACK_POINTER: begin
                    if (pwrite) begin
                        next_s.ptr = pwdata[prs_pkg::PTR_W-1:0]; // [RQ23]
                        // flags only clear; a one written leaves them alone
                        next_s.stack_full_flag = s.stack_full_flag
                                                 & pwdata[prs_pkg::FULL_BIT]; // [RQ19] [RQ23]
                        next_s.stack_underflow_flag = s.stack_underflow_flag
                                                      & pwdata[prs_pkg::UNF_BIT]; // [RQ19] [RQ23]
                    end
                    next_s.prdata = {24'h000000, s.stack_full_flag, s.stack_underflow_flag,
                                     1'b0, s.ptr}; // [RQ19]
                end
                prs_pkg::OFS_CONFIG: begin
                    if (pwrite) begin
                        next_s.overflow_reset_enable = pwdata[prs_pkg::CFG_OVR_BIT];
                    end
                    next_s.prdata = {31'h00000000, s.overflow_reset_enable};
                end
                prs_pkg::OFS_COUNTER_VIEW: begin
                    next_s.prdata = {11'h000, s.pc};
                end
                default: begin
                    next_s.pslverr = 1'b1;
                end
            endcase
        end

        // core side runs after the bus so an event in the clear cycle still sets its flag
        if (cmd.valid) begin
            case (cmd.op)
                prs_pkg::OP_STEP: begin
                    next_s.pc = s.pc + prs_pkg::PC_STEP; // [RQ6]
                end
                prs_pkg::OP_JUMP: begin
                    next_s.pc = cmd.target; // [RQ7]
                end
                prs_pkg::OP_CALL: begin
                    push = 1'b1; // [RQ8]
                    next_s.pc = cmd.target; // [RQ7]
                    if (cmd.fast) begin
                        next_s.shadow = cmd.save; // [RQ22]
                    end
                end
                prs_pkg::OP_RETURN, prs_pkg::OP_RETURN_FROM_INTERRUPT: begin
                    pop = 1'b1; // [RQ8]
                    pop_load = 1'b1;
                    if (cmd.fast) begin
                        next_s.restore = s.shadow; // [RQ21] [RQ22]
                        next_s.restore_valid = 1'b1;
                    end
                end
                prs_pkg::OP_PUSH: begin
                    push = 1'b1; // [RQ20]
                end
                prs_pkg::OP_POP: begin
                    pop = 1'b1; // [RQ20]
                end
                prs_pkg::OP_INT_HI, prs_pkg::OP_INT_LO: begin
                    push = 1'b1; // [RQ8]
                    next_s.pc = (cmd.op == prs_pkg::OP_INT_HI) ? prs_pkg::VEC_INT_HI
                                                               : prs_pkg::VEC_INT_LO; // [RQ2]
                    next_s.shadow = cmd.save; // [RQ21]
                end
                prs_pkg::OP_WRITE_LOW: begin
                    next_s.pc = {s.counter_upper_latch, s.counter_high_latch,
                                 cmd.low_data}; // [RQ4]
                end
                prs_pkg::OP_READ_LOW: begin
                    next_s.read_low_data = s.pc[7:0];
                    next_s.counter_high_latch = s.pc[15:8]; // [RQ5]
                    next_s.counter_upper_latch = s.pc[20:16]; // [RQ5]
                end
                default: begin
                    next_s.pc = next_s.pc;
                end
            endcase
        end

        if (push) begin
            if (s.ptr == prs_pkg::PTR_FULL) begin
                next_s.stack_full_flag = 1'b1; // [RQ16]
            end else if (s.ptr == prs_pkg::PTR_LAST_FREE) begin
                next_s.stack_full_flag = 1'b1; // [RQ14]
                if (s.overflow_reset_enable) begin
                    next_s.stk[s.ptr] = push_val + prs_pkg::PC_STEP; // [RQ15]
                    next_s.ptr = prs_pkg::PTR_EMPTY; // [RQ15] [RQ18]
                    next_s.pc = prs_pkg::VEC_RESET; // [RQ2]
                    next_s.device_reset = 1'b1; // [RQ18]
                end else begin
                    next_s.stk[s.ptr] = push_val; // [RQ16]
                    next_s.ptr = prs_pkg::PTR_FULL; // [RQ16]
                end
            end else begin
                // new index ptr+1 maps to storage slot ptr
                next_s.stk[s.ptr] = push_val; // [RQ9] [RQ10]
                next_s.ptr = s.ptr + 5'h01; // [RQ10]
            end
        end

        if (pop) begin
            if (s.ptr == prs_pkg::PTR_EMPTY) begin
                next_s.stack_underflow_flag = 1'b1; // [RQ17]
                if (pop_load) begin
                    next_s.pc = prs_pkg::VEC_RESET; // [RQ17]
                end
                if (s.overflow_reset_enable) begin
                    next_s.pc = prs_pkg::VEC_RESET;
                    next_s.device_reset = 1'b1; // [RQ18]
                end
            end else begin
                if (pop_load) begin
                    next_s.pc = s.stk[s.ptr - 5'h01]; // [RQ10]
                end
                next_s.ptr = s.ptr - 5'h01; // [RQ10] [RQ20]
            end
        end

        next_s.pc[0] = 1'b0; // [RQ6]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0; // [RQ11]
            s.overflow_reset_enable <= prs_pkg::CFG_OVR_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign pc = s.pc;
    assign fetch_word = s.fetch_word;
    assign read_low_data = s.read_low_data;
    assign restore_valid = s.restore_valid;
    assign restore = s.restore;
    assign device_reset = s.device_reset;
    assign return_stack_pointer = {s.stack_full_flag, s.stack_underflow_flag, 1'b0, s.ptr};

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic core_call;
    logic core_step;
    logic core_pop0;
    assign core_call = cmd.valid && (cmd.op == prs_pkg::OP_INT_HI);
    assign core_step = cmd.valid && (cmd.op == prs_pkg::OP_STEP);
    assign core_pop0 = cmd.valid && (cmd.op == prs_pkg::OP_RETURN)
                       && (s.ptr == prs_pkg::PTR_EMPTY);

    // pairs need the bus idle; collisions exclude only the clashing bus write, or for the latch check any core command
    chk_pc_lsb_zero: assert property ( // [RQ6]
        pc[0] == 1'b0)
        else $error("counter bit 0 is not zero");

    chk_step_adds_two: assert property ( // [RQ6]
        core_step && !apb_wr_low
        |=> pc == (($past(pc) + 21'h000002) & 21'h1ffffe))
        else $error("sequential step did not add two");

    chk_int_vector_hi: assert property ( // [RQ2]
        core_call && s.ptr != prs_pkg::PTR_LAST_FREE
        |=> pc == 21'h000008 && restore_valid == 1'b0)
        else $error("high interrupt did not vector to 0008h");

    chk_reset_clears_ptr: assert property ( // [RQ11]
        device_reset
        |-> pc == 21'h000000 && return_stack_pointer[4:0] == 5'h00)
        else $error("device reset left pointer or counter nonzero");

    chk_full_holds_ptr: assert property ( // [RQ16]
        cmd.valid && cmd.op inside {prs_pkg::OP_PUSH, prs_pkg::OP_CALL}
        && s.ptr == prs_pkg::PTR_FULL && !apb_wr_ptr
        |=> return_stack_pointer[4:0] == 5'h1f && return_stack_pointer[7])
        else $error("pointer left 31 or full flag dropped on extra push");

    chk_underflow_pop: assert property ( // [RQ17]
        core_pop0
        |=> pc == 21'h000000 && return_stack_pointer[6]
        && return_stack_pointer[4:0] == 5'h00)
        else $error("pop at empty stack misbehaved");

    chk_full_sticky: assert property ( // [RQ14]
        return_stack_pointer[7] && !apb_wr_ptr
        |=> return_stack_pointer[7])
        else $error("full flag cleared without software write");

    chk_latch_to_pc: assert property ( // [RQ4]
        apb_wr_low && !cmd.valid
        |=> pc[20:8] == $past({s.counter_upper_latch, s.counter_high_latch}))
        else $error("low byte write did not load latches into counter");

    chk_push_pop_pair: assert property ( // [RQ10]
        cmd.valid && cmd.op == prs_pkg::OP_CALL && !apb_go
        && s.ptr < prs_pkg::PTR_LAST_FREE ##1 cmd.valid && cmd.op == prs_pkg::OP_RETURN && !apb_go
        |=> pc == $past(pc, 2)
        && return_stack_pointer[4:0] == $past(return_stack_pointer[4:0], 2))
        else $error("call then return did not restore counter and pointer");

    chk_fetch_blank: assert property ( // [RQ1]
        pc >= MEM_BYTES
        |=> fetch_word == 16'h0000)
        else $error("fetch beyond memory not zero");

    chk_jump_direct: assert property ( // [RQ7]
        cmd.valid && cmd.op == prs_pkg::OP_JUMP
        |=> pc[20:1] == $past(cmd.target[20:1]))
        else $error("jump did not load its target");

    chk_unf_sticky: assert property ( // [RQ17]
        return_stack_pointer[6] && !apb_wr_ptr
        |=> return_stack_pointer[6])
        else $error("underflow flag cleared without software write");

    chk_fast_restore: assert property ( // [RQ21]
        cmd.valid && cmd.fast && cmd.op == prs_pkg::OP_RETURN_FROM_INTERRUPT
        |=> restore_valid && restore == $past(s.shadow))
        else $error("fast interrupt return did not restore shadow");

    cov_overflow_reset: cover property (device_reset && return_stack_pointer[7]);
    cov_underflow: cover property (core_pop0);
    cov_fast_restore: cover property (restore_valid);
    cov_ptr_full: cover property (return_stack_pointer[4:0] == 5'h1f);

endmodule : prs_counter_stack

/* File: prs_pkg.sv */
// shared constants, command codes and carriers for the counter and return stack unit
package prs_pkg;

    localparam int PC_W = 21;
    localparam int PTR_W = 5;
    localparam int STK_DEPTH = 31;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 8;

    localparam logic [PC_W-1:0] VEC_RESET = 21'h000000;
    localparam logic [PC_W-1:0] VEC_INT_HI = 21'h000008;
    localparam logic [PC_W-1:0] VEC_INT_LO = 21'h000018;
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
    localparam logic [PTR_W-1:0] PTR_EMPTY = 5'h00;
    localparam logic [PTR_W-1:0] PTR_LAST_FREE = 5'h1e;
    localparam logic [PTR_W-1:0] PTR_FULL = 5'h1f;

    // register byte offsets on the bus
    localparam logic [ADDR_W-1:0] OFS_COUNTER_LOW = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_HIGH_LATCH = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_UPPER_LATCH = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_TOP_LOW = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_TOP_HIGH = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_TOP_UPPER = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_STACK_POINTER = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_CONFIG = 8'h1c;
    localparam logic [ADDR_W-1:0] OFS_COUNTER_VIEW = 8'h20;

    // return_stack_pointer flag fields, then the config enable bit and its reset value
    localparam int FULL_BIT = 7;
    localparam int UNF_BIT = 6;
    localparam int CFG_OVR_BIT = 0;
    localparam logic CFG_OVR_RESET = 1'b1;

    typedef enum logic [3:0] {
        OP_NONE = 4'b0000,
        OP_STEP = 4'b0001,
        OP_JUMP = 4'b0010,
        OP_CALL = 4'b0011,
        OP_RETURN = 4'b0100,
        OP_RETURN_FROM_INTERRUPT = 4'b0101,
        OP_PUSH = 4'b0110,
        OP_POP = 4'b0111,
        OP_INT_HI = 4'b1000,
        OP_INT_LO = 4'b1001,
        OP_WRITE_LOW = 4'b1010,
        OP_READ_LOW = 4'b1011
    } prs_op_e;

    typedef struct packed {
        logic [7:0] status;
        logic [7:0] working_register;
        logic [7:0] bank_select_register;
    } prs_shadow_s;

    typedef struct packed {
        logic valid;
        prs_op_e op;
        logic fast;
        logic [PC_W-1:0] target;
        logic [7:0] low_data;
        prs_shadow_s save;
    } prs_cmd_s;

endpackage : prs_pkg

/* File: tb_prs_counter_stack.sv */
// self-checking bench for the counter and return stack unit
`timescale 1ns/1ps
module tb_prs_counter_stack;
    localparam logic [20:0] MEM = 21'h000100;
    localparam int LIMIT = 20000;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, restore_valid, device_reset;
    prs_pkg::prs_cmd_s cmd;
    logic [15:0] flash_rdata, fetch_word;
    logic [20:0] pc, pcm, t;
    logic [7:0] read_low_data, return_stack_pointer;
    prs_pkg::prs_shadow_s restore, sv;
    logic [33:0] rd_q[$];
    logic [23:0] rs_q[$];
    int bad_count = 0, num_checks = 0, cycles = 0, resets = 0;

    always #2 pclk = ~pclk;

    prs_counter_stack #(.MEM_BYTES(MEM)) u_prs_counter_stack (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd(cmd),
        .flash_rdata(flash_rdata), .pc(pc), .fetch_word(fetch_word),
        .read_low_data(read_low_data), .restore_valid(restore_valid), .restore(restore),
        .device_reset(device_reset), .return_stack_pointer(return_stack_pointer));
    prs_core_model u_prs_core_model (.pclk(pclk), .pc(pc), .cmd(cmd),
        .flash_rdata(flash_rdata));

    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test

    // every transfer notes its expectation; the monitor judges only those marked for checking
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic chk, input logic err, input logic [31:0] exp);
        rd_q.push_back({chk, err, exp});
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 1'b0, 1'b0, 32'h0);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 1'b1, 1'b0, exp);
    endtask : rd

    task automatic go(input prs_pkg::prs_op_e o, input logic f, input logic [20:0] tg,
                      input logic [7:0] lo);
        u_prs_core_model.issue(o, f, tg, sv, lo);
    endtask : go

    task automatic burst(input logic [20:0] base);
        for (int i = 1; i <= 31; i++) begin
            go(prs_pkg::OP_CALL, 1'b0, base + 21'(2 * i), 8'h00);
            if (i == 30)
                rd(prs_pkg::OFS_STACK_POINTER, 32'h1e);
        end
    endtask : burst

    task automatic done(input string name);
        $display("test %s done", name);
    endtask : done

    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && rd_q.size() > 0) begin
            if (rd_q[0][33])
                check({pslverr, prdata}, rd_q[0][32:0]);
            void'(rd_q.pop_front());
        end
        if (restore_valid === 1'b1)
            check({9'h0, restore}, {9'h0, rs_q.pop_front()});
        if (device_reset === 1'b1)
            resets++;
    end

    always @(posedge pclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            bad_count++;
            end_of_test();
        end
    end

    initial begin
        void'($urandom(32'h12b59575));
        sv = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(prs_pkg::OFS_STACK_POINTER, 32'h0);
        rd(prs_pkg::OFS_CONFIG, 32'h1);
        rd(prs_pkg::OFS_COUNTER_VIEW, 32'h0);
        apb(1'b0, 8'h24, 32'h0, 1'b1, 1'b1, 32'h0);
        done("reset");
        go(prs_pkg::OP_STEP, 1'b0, 21'h0, 8'h00);
        go(prs_pkg::OP_STEP, 1'b0, 21'h0, 8'h00);
        go(prs_pkg::OP_NONE, 1'b0, 21'h0000fe, 8'h00);
        rd(prs_pkg::OFS_COUNTER_VIEW, 32'h4);
        go(prs_pkg::OP_JUMP, 1'b0, MEM - 21'h2, 8'h00);
        repeat (2) @(negedge pclk);
        check({17'h0, fetch_word}, {17'h0, (MEM[15:0] - 16'h2) ^ 16'ha55a});
        go(prs_pkg::OP_STEP, 1'b0, 21'h0, 8'h00);
        repeat (2) @(negedge pclk);
        check({17'h0, fetch_word}, 33'h0);
        done("fetch");
        wr(prs_pkg::OFS_HIGH_LATCH, 32'h12);
        wr(prs_pkg::OFS_UPPER_LATCH, 32'h03);
        go(prs_pkg::OP_JUMP, 1'b0, 21'h005678, 8'h00);
        rd(prs_pkg::OFS_HIGH_LATCH, 32'h12);
        wr(prs_pkg::OFS_COUNTER_LOW, 32'h34);
        rd(prs_pkg::OFS_COUNTER_VIEW, 32'h031234);
        rd(prs_pkg::OFS_COUNTER_LOW, 32'h34);
        go(prs_pkg::OP_JUMP, 1'b0, 21'h1abcde, 8'h00);
        go(prs_pkg::OP_READ_LOW, 1'b0, 21'h0, 8'h00);
        @(negedge pclk);
        check({25'h0, read_low_data}, 33'hde);
        rd(prs_pkg::OFS_HIGH_LATCH, 32'hbc);
        rd(prs_pkg::OFS_UPPER_LATCH, 32'h1a);
        go(prs_pkg::OP_WRITE_LOW, 1'b0, 21'h0, 8'h40);
        pcm = 21'h1abc40;
        rd(prs_pkg::OFS_COUNTER_VIEW, {11'h0, pcm});
        done("latches");
        repeat (4) begin
            t = 21'($urandom) & 21'h1ffffe;
            go(prs_pkg::OP_CALL, 1'b0, t, 8'h00);
            rd(prs_pkg::OFS_TOP_LOW, {24'h0, pcm[7:0]});
            rd(prs_pkg::OFS_TOP_HIGH, {24'h0, pcm[15:8]});
            rd(prs_pkg::OFS_TOP_UPPER, {27'h0, pcm[20:16]});
            rd(prs_pkg::OFS_STACK_POINTER, 32'h1);
            rd(prs_pkg::OFS_COUNTER_VIEW, {11'h0, t});
            check({4'h0, return_stack_pointer, pc}, {4'h0, 8'h01, t});
            go(prs_pkg::OP_RETURN, 1'b0, 21'h0, 8'h00);
            rd(prs_pkg::OFS_COUNTER_VIEW, {11'h0, pcm});
            rd(prs_pkg::OFS_STACK_POINTER, 32'h0);
        end
        rd(prs_pkg::OFS_HIGH_LATCH, 32'hbc);
        u_prs_core_model.call_return(21'h000300);
        rd(prs_pkg::OFS_COUNTER_VIEW, {11'h0, pcm});
        done("call");
        sv = 24'($urandom);
        go(prs_pkg::OP_INT_LO, 1'b0, 21'h0, 8'h00);
        rd(prs_pkg::OFS_COUNTER_VIEW, 32'h18);
        sv = 24'($urandom);
        rs_q.push_back(sv);
        go(prs_pkg::OP_INT_HI, 1'b0, 21'h0, 8'h00);
        rd(prs_pkg::OFS_COUNTER_VIEW, 32'h8);
        sv = ~sv;
        go(prs_pkg::OP_RETURN_FROM_INTERRUPT, 1'b1, 21'h0, 8'h00);
        rd(prs_pkg::OFS_COUNTER_VIEW, 32'h18);
        go(prs_pkg::OP_RETURN_FROM_INTERRUPT, 1'b0, 21'h0, 8'h00);
        sv = 24'($urandom);
        rs_q.push_back(sv);
        go(prs_pkg::OP_CALL, 1'b1, 21'h000200, 8'h00);
        sv = ~sv;
        go(prs_pkg::OP_RETURN, 1'b1, 21'h0, 8'h00);
        rd(prs_pkg::OFS_COUNTER_VIEW, {11'h0, pcm});
        done("shadow");
        go(prs_pkg::OP_PUSH, 1'b0, 21'h0, 8'h00);
        rd(prs_pkg::OFS_TOP_LOW, {24'h0, pcm[7:0]});
        go(prs_pkg::OP_POP, 1'b0, 21'h0, 8'h00);
        rd(prs_pkg::OFS_STACK_POINTER, 32'h0);
        rd(prs_pkg::OFS_COUNTER_VIEW, {11'h0, pcm});
        rd(prs_pkg::OFS_TOP_LOW, 32'h0);
        wr(prs_pkg::OFS_STACK_POINTER, 32'h1);
        rd(prs_pkg::OFS_TOP_LOW, {24'h0, pcm[7:0]});
        wr(prs_pkg::OFS_TOP_LOW, 32'h66);
        go(prs_pkg::OP_RETURN, 1'b0, 21'h0, 8'h00);
        rd(prs_pkg::OFS_COUNTER_VIEW, {11'h0, pcm[20:8], 8'h66});
        done("software stack");
        wr(prs_pkg::OFS_CONFIG, 32'h0);
        go(prs_pkg::OP_RETURN, 1'b0, 21'h0, 8'h00);
        rd(prs_pkg::OFS_STACK_POINTER, 32'h40);
        rd(prs_pkg::OFS_COUNTER_VIEW, 32'h0);
        check(33'(resets), 33'h0);
        wr(prs_pkg::OFS_STACK_POINTER, 32'hc0);
        rd(prs_pkg::OFS_STACK_POINTER, 32'h40);
        wr(prs_pkg::OFS_STACK_POINTER, 32'h0);
        burst(21'h000400);
        rd(prs_pkg::OFS_STACK_POINTER, 32'h9f);
        go(prs_pkg::OP_CALL, 1'b0, 21'h000500, 8'h00);
        rd(prs_pkg::OFS_STACK_POINTER, 32'h9f);
        rd(prs_pkg::OFS_TOP_LOW, 32'h3c);
        done("overflow hold");
        wr(prs_pkg::OFS_STACK_POINTER, 32'h0);
        wr(prs_pkg::OFS_CONFIG, 32'h1);
        rd(prs_pkg::OFS_STACK_POINTER, 32'h0);
        burst(21'h000600);
        rd(prs_pkg::OFS_STACK_POINTER, 32'h80);
        rd(prs_pkg::OFS_COUNTER_VIEW, 32'h0);
        check(33'(resets), 33'h1);
        wr(prs_pkg::OFS_STACK_POINTER, 32'h9f);
        rd(prs_pkg::OFS_TOP_LOW, 32'h3e);
        rd(prs_pkg::OFS_TOP_HIGH, 32'h06);
        wr(prs_pkg::OFS_STACK_POINTER, 32'h0);
        go(prs_pkg::OP_RETURN, 1'b0, 21'h0, 8'h00);
        rd(prs_pkg::OFS_STACK_POINTER, 32'h40);
        check(33'(resets), 33'h2);
        done("overflow reset");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(prs_pkg::OFS_STACK_POINTER, 32'h0);
        done("second reset");
        end_of_test();
    end
endmodule : tb_prs_counter_stack
